// ### inc/acc_pkg.sv
// Package for the converter control block: register map, fields, timing and carriers.
// Assumes a plain address/strobe register port and one 50 MHz clock.
package acc_pkg;
    localparam logic [2:0] ADDR_CONTROL = 3'h0;
    localparam logic [2:0] ADDR_RES_HIGH = 3'h1;
    localparam logic [2:0] ADDR_RES_LOW = 3'h2;
    localparam logic [2:0] ADDR_CLOCK_SEL = 3'h3;
    localparam logic [2:0] ADDR_IRQ = 3'h4;
    localparam logic [2:0] ADDR_STATUS = 3'h5;
    localparam int BIT_JUSTIFY = 7;
    localparam int BIT_REFSEL = 6;
    localparam int BIT_CHAN_LO = 2;
    localparam int BIT_GO = 1;
    localparam int BIT_ENABLE = 0;
    localparam int BIT_DONE_FLAG = 0;
    localparam int BIT_IRQ_EN = 1;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] CONTROL_WMASK = 8'hDF;
    localparam logic [2:0] CLKSEL_RESET = 3'h0;
    localparam logic [9:0] RESULT_RESET = 10'h000;
    localparam int CONV_BIT_PERIODS = 11;
    localparam int ABORT_BIT_PERIODS = 2;
    localparam int RC_PERIOD_NS = 4000;
    localparam int CLK_PERIOD_NS = 20;
    localparam int RC_DIV_CYCLES = (RC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INSTR_NS = 80;
    localparam int INSTR_CYCLES = (INSTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] CHAN_RESERVED = 3'h7;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } acc_bus_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [2:0] clk_sel;
        logic irq_en;
        logic done_flag;
    } acc_regs_t;

    typedef struct packed {
        logic powered;
        logic sampling;
        logic converting;
        logic ref_external;
        logic [2:0] channel;
    } acc_analog_t;
endpackage : acc_pkg

// ### hw/acc_divider.sv
// Bit period enable generator for the converter control block.
// Assumes one clock; produces a one-cycle enable each selected bit period.
`timescale 1ns/100ps
`default_nettype none
module acc_divider #(
    parameter int RC_DIV = acc_pkg::RC_DIV_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [2:0] clk_sel,
    output logic tick
);
    import acc_pkg::*;

    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } acc_div_state_t;

    acc_div_state_t s_q, s_d;

    function automatic logic [7:0] div_last(input logic [2:0] sel);
        logic [7:0] n;
        n = 8'h00;
        unique case (sel)
            3'h0: n = 8'h01;
            3'h4: n = 8'h03;
            3'h1: n = 8'h07;
            3'h5: n = 8'h0F;
            3'h2: n = 8'h1F;
            3'h6: n = 8'h3F;
            default: n = 8'(RC_DIV - 1);
        endcase
        return n;
    endfunction : div_last

    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (!run) begin
            s_d.cnt = 8'h00;
        end else if (s_q.cnt >= div_last(clk_sel)) begin
            s_d.cnt = 8'h00;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;
endmodule : acc_divider
`default_nettype wire

// ### hw/acc_top.sv
// Converter control block: control register, sequencing, result pair.
// Summary of operation
// - justify bit 1 gives right justified result, 0 gives left justified.
// - converter runs only while enable bit is 1.
// - writing start bit begins conversion; bit reads 1 while converting.
// - on completion clear start bit, set done flag, load result.
// - software clearing start aborts; result pair keeps previous value.
// - after abort wait 2 bit periods, then acquisition restarts.
// - reset returns all registers to reset values, converter off.
// - internal RC clock delays conversion start one instruction cycle.
// - Sleep with RC: wake if irq enabled, else shut off, enable kept.
// - Sleep with other clock aborts and shuts off, enable kept.
// - special event trigger sets start bit and resets trigger timer.
// - channel field selects four inputs, references; 111 reserved.
// - reference select 1 picks external pin, 0 the supply.
// - left justified: high holds bits 9..2, low 7..6 bits 1..0.
// - right justified: high 1..0 holds bits 9..8, low holds 7..0.
// - done flag set every conversion, cleared only by software.
// - a conversion takes 11 bit periods.
// - clock field picks system clock divisor or internal RC.
// Assumes the analog comparator answers per bit period on SAR_COMPARE.
`timescale 1ns/100ps
`default_nettype none
module acc_top #(
    parameter int RESULT_BITS = 10
) (
    input wire logic REF_CLK,
    input wire logic RESET_N,
    input wire acc_pkg::acc_bus_t BUS,
    output logic [7:0] RDATA,
    input wire logic SLEEP_REQ,
    input wire logic SPECIAL_TRIGGER,
    input wire logic SAR_COMPARE,
    output acc_pkg::acc_analog_t ANALOG,
    output logic [RESULT_BITS-1:0] SAR_TRIAL,
    output logic TIMER_CLEAR,
    output logic WAKE,
    output logic DONE_IRQ
);
    import acc_pkg::*;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_DELAY = 5'b00010,
        ST_CONV = 5'b00100,
        ST_ABORT = 5'b01000,
        ST_OFF = 5'b10000
    } acc_state_t;

    typedef struct packed {
        acc_regs_t regs;
        acc_state_t st;
        logic [3:0] bits;
        logic [2:0] dly;
        logic [9:0] sar;
        logic [9:0] result;
        logic [7:0] rdata;
        logic timer_clear;
        logic wake;
        logic [2:0] cmp_sync;
        logic [2:0] trg_sync;
        logic [2:0] slp_sync;
        logic trg_prev;
        logic [2:0] lvl;
    } acc_top_state_t;

    acc_top_state_t s_q, s_d;
    logic tick;
    logic div_run;
    logic is_rc;
    logic cmp_bit;
    logic trg_lvl;
    logic slp_lvl;
    logic trg_edge;
    logic ana_powered;

    function automatic logic [7:0] result_byte(input logic [9:0] r, input logic right, input logic high);
        logic [7:0] b;
        b = 8'h00;
        if (right) begin
            b = high ? {6'h00, r[9:8]} : r[7:0];
        end else begin
            b = high ? r[9:2] : {r[1:0], 6'h00};
        end
        return b;
    endfunction : result_byte

    // A pin change counts once the second and third stages agree; until then the old level holds
    function automatic logic filt_level(input logic [2:0] sync, input logic held);
        logic lvl;
        lvl = held;
        if (sync[2] == sync[1]) begin
            lvl = sync[1];
        end
        return lvl;
    endfunction : filt_level

    function automatic logic is_busy(input acc_state_t st);
        return (st == ST_DELAY) || (st == ST_CONV);
    endfunction : is_busy

    assign cmp_bit = filt_level(s_q.cmp_sync, s_q.lvl[0]);
    assign trg_lvl = filt_level(s_q.trg_sync, s_q.lvl[1]);
    assign slp_lvl = filt_level(s_q.slp_sync, s_q.lvl[2]);
    assign trg_edge = trg_lvl && !s_q.trg_prev;
    assign is_rc = (s_q.regs.clk_sel[1:0] == 2'b11);
    // The divider stays cleared for the first abort cycle, so the wait counts
    // whole bit periods instead of a partial one left over from the conversion
    assign div_run = s_q.regs.ctrl[BIT_ENABLE]
        && ((s_q.st == ST_CONV) || (s_q.st == ST_ABORT && s_q.dly == 3'h0));

    acc_divider u_div (
        .clk(REF_CLK),
        .rst_n(RESET_N),
        .run(div_run),
        .clk_sel(s_q.regs.clk_sel),
        .tick(tick)
    );

    always_comb begin
        logic sw_go_write;
        logic sw_go_clear;
        logic done_evt;
        logic [7:0] wv;
        sw_go_write = 1'b0;
        sw_go_clear = 1'b0;
        done_evt = 1'b0;
        wv = BUS.wdata & CONTROL_WMASK;
        s_d = s_q;
        s_d.timer_clear = 1'b0;
        s_d.cmp_sync = {s_q.cmp_sync[1:0], SAR_COMPARE};
        s_d.trg_sync = {s_q.trg_sync[1:0], SPECIAL_TRIGGER};
        s_d.slp_sync = {s_q.slp_sync[1:0], SLEEP_REQ};
        s_d.trg_prev = trg_lvl;
        s_d.lvl = {slp_lvl, trg_lvl, cmp_bit};
        if (!slp_lvl) begin
            s_d.wake = 1'b0;
        end

        if (BUS.wr) begin
            unique case (BUS.addr)
                ADDR_CONTROL: begin
                    s_d.regs.ctrl = wv;
                    sw_go_write = wv[BIT_GO] && !s_q.regs.ctrl[BIT_GO];
                    sw_go_clear = !wv[BIT_GO] && s_q.regs.ctrl[BIT_GO];
                end
                ADDR_CLOCK_SEL: s_d.regs.clk_sel = BUS.wdata[2:0];
                ADDR_IRQ: begin
                    s_d.regs.irq_en = BUS.wdata[BIT_IRQ_EN];
                    s_d.regs.done_flag = BUS.wdata[BIT_DONE_FLAG];
                end
                default: ;
            endcase
        end

        // Trigger acts on its rising edge only
        if (trg_edge && s_q.regs.ctrl[BIT_ENABLE]) begin
            s_d.regs.ctrl[BIT_GO] = 1'b1;
            s_d.timer_clear = 1'b1;
            sw_go_write = 1'b1;
        end

        unique case (s_q.st)
            ST_IDLE, ST_OFF: begin
                if (sw_go_write && s_d.regs.ctrl[BIT_ENABLE]) begin
                    s_d.st = ST_DELAY;
                    s_d.dly = is_rc ? 3'(INSTR_CYCLES) : 3'h0;
                end else if (sw_go_write) begin
                    s_d.regs.ctrl[BIT_GO] = 1'b0;
                end
            end
            ST_DELAY: begin
                if (s_q.dly == 3'h0) begin
                    s_d.st = ST_CONV;
                    s_d.bits = 4'h0;
                    s_d.sar = 10'h200;
                end else begin
                    s_d.dly = s_q.dly - 3'h1;
                end
            end
            // Limitation: the comparator answer needs about four cycles through its
            // synchroniser, so the two fastest clock choices decide on a stale answer
            ST_CONV: begin
                if (tick) begin
                    if (s_q.bits != 4'h0) begin
                        // Bit decided: keep trial if comparator says input is above
                        if (!cmp_bit) begin
                            s_d.sar = s_q.sar & ~(10'h200 >> (s_q.bits - 4'h1));
                        end
                        // Next trial bit; after the last decision the shift runs out to zero
                        s_d.sar = s_d.sar | (10'h200 >> s_q.bits);
                    end
                    if (s_q.bits == 4'(CONV_BIT_PERIODS - 1)) begin
                        done_evt = 1'b1;
                    end else begin
                        s_d.bits = s_q.bits + 4'h1;
                    end
                end
            end
            ST_ABORT: begin
                // Starts are refused until the wait is over
                s_d.regs.ctrl[BIT_GO] = 1'b0;
                if (s_q.dly != 3'h0) begin
                    s_d.dly = s_q.dly - 3'h1;
                end else if (tick) begin
                    if (s_q.bits == 4'(ABORT_BIT_PERIODS - 1)) begin
                        s_d.st = ST_IDLE;
                    end else begin
                        s_d.bits = s_q.bits + 4'h1;
                    end
                end
            end
            default: s_d.st = ST_IDLE;
        endcase

        // Completion is applied after the bus write, so a set beats a clear in the same cycle
        if (done_evt) begin
            s_d.st = ST_IDLE;
            s_d.regs.ctrl[BIT_GO] = 1'b0;
            s_d.regs.done_flag = 1'b1;
            s_d.result = s_d.sar;
            if (slp_lvl && s_q.regs.irq_en) begin
                s_d.wake = 1'b1;
            end else if (slp_lvl) begin
                s_d.st = ST_OFF;
            end
        end else if (is_busy(s_q.st) && sw_go_clear) begin
            s_d.st = ST_ABORT;
            s_d.bits = 4'h0;
            s_d.dly = 3'h1;
        end else if (is_busy(s_q.st) && slp_lvl && !is_rc) begin
            s_d.st = ST_OFF;
            s_d.regs.ctrl[BIT_GO] = 1'b0;
        end

        if (!s_d.regs.ctrl[BIT_ENABLE]) begin
            s_d.st = ST_IDLE;
            s_d.regs.ctrl[BIT_GO] = 1'b0;
        end else if (s_q.st == ST_OFF && !slp_lvl && s_d.st == ST_OFF) begin
            s_d.st = ST_IDLE;
        end

        s_d.rdata = 8'h00;
        if (BUS.rd) begin
            unique case (BUS.addr)
                ADDR_CONTROL: s_d.rdata = s_q.regs.ctrl;
                ADDR_RES_HIGH: s_d.rdata = result_byte(s_q.result, s_q.regs.ctrl[BIT_JUSTIFY], 1'b1);
                ADDR_RES_LOW: s_d.rdata = result_byte(s_q.result, s_q.regs.ctrl[BIT_JUSTIFY], 1'b0);
                ADDR_CLOCK_SEL: s_d.rdata = {5'h00, s_q.regs.clk_sel};
                ADDR_IRQ: s_d.rdata = {6'h00, s_q.regs.irq_en, s_q.regs.done_flag};
                ADDR_STATUS: s_d.rdata = {3'h0, s_q.st};
                default: s_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            s_q.regs <= '{ctrl: CONTROL_RESET, clk_sel: CLKSEL_RESET, irq_en: 1'b0, done_flag: 1'b0};
            s_q.st <= ST_IDLE;
            s_q.bits <= 4'h0;
            s_q.dly <= 3'h0;
            s_q.sar <= RESULT_RESET;
            s_q.result <= RESULT_RESET;
            s_q.rdata <= 8'h00;
            s_q.timer_clear <= 1'b0;
            s_q.wake <= 1'b0;
            s_q.cmp_sync <= 3'h0;
            s_q.trg_sync <= 3'h0;
            s_q.slp_sync <= 3'h0;
            s_q.trg_prev <= 1'b0;
            s_q.lvl <= 3'h0;
        end else begin
            s_q <= s_d;
        end
    end

    assign RDATA = s_q.rdata;
    // One driver for the whole carrier; acquisition resumes by itself once an abort wait ends
    assign ana_powered = s_q.regs.ctrl[BIT_ENABLE] && (s_q.st != ST_OFF);
    assign ANALOG = '{
        powered: ana_powered,
        sampling: ana_powered && (s_q.st == ST_IDLE),
        converting: (s_q.st == ST_CONV),
        ref_external: s_q.regs.ctrl[BIT_REFSEL],
        channel: s_q.regs.ctrl[BIT_CHAN_LO +: 3]
    };
    assign SAR_TRIAL = s_q.sar[RESULT_BITS-1:0];
    assign TIMER_CLEAR = s_q.timer_clear;
    assign WAKE = s_q.wake;
    assign DONE_IRQ = s_q.regs.done_flag && s_q.regs.irq_en;
endmodule : acc_top
`default_nettype wire

// ### testbench/acc_top_sva.sv
// Port checker for the converter control block.
// Assumes the register map and fields of acc_pkg; bound onto acc_top.
`timescale 1ns/100ps
`default_nettype none
module acc_top_sva (
    input wire logic REF_CLK,
    input wire logic RESET_N,
    input wire acc_pkg::acc_bus_t BUS,
    input wire acc_pkg::acc_analog_t ANALOG,
    input wire logic SPECIAL_TRIGGER,
    input wire logic TIMER_CLEAR,
    input wire logic WAKE,
    input wire logic DONE_IRQ
);
    import acc_pkg::*;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESET_N);
    wire ctl_wr = BUS.wr && BUS.addr == ADDR_CONTROL;
    a_power_gate: assert property (ANALOG.converting |-> ANALOG.powered)
        else $error("converting while unpowered");
    a_disable_stops: assert property (ctl_wr && !BUS.wdata[0] |=> !ANALOG.powered && !ANALOG.converting)
        else $error("disable did not stop converter");
    a_abort_stops: assert property (ctl_wr && BUS.wdata[0] && !BUS.wdata[1] && ANALOG.converting
        |-> ##[1:2] !ANALOG.converting)
        else $error("abort did not stop conversion");
    a_ref_follows: assert property (ctl_wr |=> ANALOG.ref_external == $past(BUS.wdata[6]))
        else $error("reference select not applied");
    a_chan_follows: assert property (ctl_wr |=> ANALOG.channel == $past(BUS.wdata[4:2]))
        else $error("channel not applied");
    a_trig_clears: assert property ($rose(SPECIAL_TRIGGER) && ANALOG.powered |-> ##[1:8] TIMER_CLEAR)
        else $error("trigger gave no timer clear");
    a_timer_pulse: assert property (TIMER_CLEAR |=> !TIMER_CLEAR)
        else $error("timer clear longer than one cycle");
    a_reset_off: assert property ($rose(RESET_N) |-> !ANALOG.powered && !DONE_IRQ && !WAKE)
        else $error("outputs not cleared by reset");
    a_wake_cause: assert property ($rose(WAKE) |-> DONE_IRQ)
        else $error("wake without enabled done flag");
    cover property ($rose(ANALOG.converting));
    cover property (TIMER_CLEAR);
    cover property ($rose(WAKE));
endmodule : acc_top_sva
bind acc_top acc_top_sva chk (.REF_CLK, .RESET_N, .BUS, .ANALOG, .SPECIAL_TRIGGER, .TIMER_CLEAR, .WAKE,
    .DONE_IRQ);
`default_nettype wire

// ### testbench/acc_top_tb.sv
// Self-checking bench for the converter control block.
// Assumes acc_pkg register map; drives every input from here, no partner.
`timescale 1ns/100ps
`default_nettype none
module acc_top_tb;
    import acc_pkg::*;
    logic clk, rst_n, sleep, trig, cmp, tclr, wake, irq, seen;
    acc_bus_t bus;
    acc_analog_t ana;
    logic [7:0] rdata, d;
    logic [9:0] trial, vin;
    int n_fail = 0;
    int n_compared = 0;
    int c;
    logic [2:0] sels [8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
    int divs [8] = '{2, 4, 8, 16, 32, 64, RC_DIV_CYCLES, RC_DIV_CYCLES};
    acc_top dut (.REF_CLK(clk), .RESET_N(rst_n), .BUS(bus), .RDATA(rdata), .SLEEP_REQ(sleep),
        .SPECIAL_TRIGGER(trig), .SAR_COMPARE(cmp), .ANALOG(ana), .SAR_TRIAL(trial),
        .TIMER_CLEAR(tclr), .WAKE(wake), .DONE_IRQ(irq));
    always #(CLK_PERIOD_NS / 2) clk = ~clk;
    // Comparator model: input at or above the trial word keeps the bit
    always @(posedge clk) cmp <= vin >= trial;
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        bus <= '{a, v, 1'b1, 1'b0};
        @(posedge clk);
        bus <= '0;
        #1;
    endtask : wr
    task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        bus <= '0;
        #1 d = rdata;
        chk({2'h0, d}, {2'h0, exp});
    endtask : rchk
    task automatic wait_done();
        c = 0;
        while (irq !== 1'b1 && c < 3000) begin
            @(posedge clk);
            #1 c++;
        end
        if (irq !== 1'b1) begin
            n_fail++;
            $display("[FAIL] %0t conversion did not finish", $time);
        end
    endtask : wait_done
    task automatic final_report();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : final_report
    initial begin
        clk = 0; rst_n = 0; bus = '0; sleep = 0; trig = 0; cmp = 0; vin = 10'h2B5;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rchk(ADDR_CONTROL, CONTROL_RESET);
        rchk(ADDR_IRQ, 8'h00);
        rchk(3'h6, 8'h00);
        wr(ADDR_CONTROL, 8'h02);
        rchk(ADDR_CONTROL, 8'h00);
        for (int ch = 0; ch < 8; ch++) begin
            wr(ADDR_CONTROL, {1'b0, ch[0], 1'b0, ch[2:0], 2'h1});
            chk(ana.channel, ch[2:0]);
            chk(ana.ref_external, ch[0]);
        end
        wr(ADDR_CONTROL, 8'h01);
        foreach (sels[i]) begin
            wr(ADDR_IRQ, 8'h02);
            chk(irq, 1'b0);
            wr(ADDR_CLOCK_SEL, {5'h00, sels[i]});
            wr(ADDR_CONTROL, 8'h03);
            wait_done();
            chk(c >= 11 * divs[i] && c <= 12 * divs[i] + 8, 1'b1);
        end
        wr(ADDR_IRQ, 8'h02);
        wr(ADDR_CLOCK_SEL, 8'h02);
        wr(ADDR_CONTROL, 8'h83);
        rchk(ADDR_CONTROL, 8'h83);
        wait_done();
        rchk(ADDR_CONTROL, 8'h81);
        rchk(ADDR_RES_HIGH, 8'h02);
        rchk(ADDR_RES_LOW, 8'hB5);
        rchk(ADDR_IRQ, 8'h03);
        wr(ADDR_IRQ, 8'h02);
        wr(ADDR_CONTROL, 8'h03);
        wait_done();
        rchk(ADDR_RES_HIGH, 8'hAD);
        rchk(ADDR_RES_LOW, 8'h40);
        wr(ADDR_IRQ, 8'h02);
        vin = 10'h155;
        wr(ADDR_CONTROL, 8'h03);
        repeat (100) @(posedge clk);
        wr(ADDR_CONTROL, 8'h01);
        rchk(ADDR_RES_HIGH, 8'hAD);
        rchk(ADDR_IRQ, 8'h02);
        chk(ana.converting, 1'b0);
        chk(ana.sampling, 1'b0);
        repeat (2 * 32 - 8) @(posedge clk);
        #1 chk(ana.sampling, 1'b0);
        repeat (16) @(posedge clk);
        #1 chk(ana.sampling, 1'b1);
        @(posedge clk) trig <= 1'b1;
        seen = 0;
        repeat (10) @(posedge clk) seen |= tclr;
        chk(seen, 1'b1);
        trig <= 1'b0;
        wait_done();
        chk(irq, 1'b1);
        wr(ADDR_IRQ, 8'h02);
        wr(ADDR_CLOCK_SEL, 8'h03);
        wr(ADDR_CONTROL, 8'h03);
        @(posedge clk) sleep <= 1'b1;
        wait_done();
        repeat (4) @(posedge clk);
        chk(wake, 1'b1);
        @(posedge clk) sleep <= 1'b0;
        repeat (8) @(posedge clk);
        chk(wake, 1'b0);
        wr(ADDR_IRQ, 8'h02);
        wr(ADDR_CLOCK_SEL, 8'h02);
        wr(ADDR_CONTROL, 8'h03);
        @(posedge clk) sleep <= 1'b1;
        repeat (10) @(posedge clk);
        chk({ana.converting, ana.powered}, 2'h0);
        rchk(ADDR_IRQ, 8'h02);
        @(posedge clk) sleep <= 1'b0;
        wr(ADDR_CONTROL, 8'h03);
        @(posedge clk) rst_n <= 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rchk(ADDR_CONTROL, CONTROL_RESET);
        chk(ana.powered, 1'b0);
        final_report();
    end
    // Whole run is near 9000 cycles; ten times that means a hang
    initial begin
        repeat (90000) @(posedge clk);
        n_fail++;
        final_report();
    end
endmodule : acc_top_tb
`default_nettype wire
